// *** src/dnf_pkg.sv ***
/*
 Shared constants for the day/night filter controller: register offsets,
 field positions, reset values, mode codes, port functions and timing.
 Assumes a single 100 MHz core clock and a plain register port.
*/
package dnf_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_THRESH = 4'h1;
    localparam logic [3:0] REG_DWELL = 4'h2;
    localparam logic [3:0] REG_LEVEL = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_IOCFG = 4'h5;

    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int STAT_NIGHT_BIT = 0;
    localparam int STAT_CROSS_BIT = 1;
    localparam int STAT_EXT_BIT = 2;
    localparam int STAT_SEL_BIT = 3;
    localparam int STAT_MODE_LSB = 4;
    localparam int IOCFG_FIELD_W = 3;
    localparam int NUM_IO = 3;

    // Mode codes held in the control register
    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_NIGHT = 2'h1;
    localparam logic [1:0] MODE_DAY = 2'h2;
    localparam logic [1:0] MODE_INPUT = 2'h3;

    // Port functions, bits [2:1] of each port field; bit 0 is direction
    localparam logic [1:0] FUNC_USER = 2'h0;
    localparam logic [1:0] FUNC_SELECT = 2'h1;
    localparam logic [1:0] FUNC_ANNOUNCE = 2'h2;

    // Reset values
    localparam logic [1:0] RST_MODE = 2'h2;
    localparam logic [15:0] RST_THRESH = 16'h0000;
    localparam logic [15:0] RST_DWELL = 16'h000A;
    localparam logic [8:0] RST_IOCFG = 9'h000;

    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int SECOND_S = 1;
    localparam int CYC_PER_SEC = CLK_HZ * SECOND_S;

    // Filter position
    typedef enum logic {POS_DAY, POS_NIGHT} dnf_pos_t;
endpackage

// *** src/dnf_ctrl.sv ***
/*
 Day/night filter controller: chooses the filter position from the
 measured darkness, the mode setting and the general-purpose pins, and
 announces the position on a configured pin. Holds the register port,
 the signed threshold compare, the dwell timer, the position decision
 and the registered pin drive.
 Assumes synchronous inputs on core_clk and a master that never needs
 wait states on the register port. Assumes the darkness level comes
 already smoothed from the scene statistics; it is compared on every
 clock. Assumes CYCLES_PER_SECOND fits the 27-bit second counter, and
 that the filter mechanism follows the two position outputs without
 needing a pulse of its own.
*/
// Summary of operation
// (RL1) Auto day: night after dark dwell
// (RL2) Auto night: day after bright dwell
// (RL3) Darkness is signed, rises when darker
// (RL4) Software threshold; higher needs darker scene
// (RL5) Dwell in seconds, shared both directions
// (RL6) Measured darkness always readable
// (RL7) Announce pin active at night position
// (RL8) Announce only on output-configured announce pin
// (RL9) Pin mode follows select input level
// (RL10) Select pin is input with select function
// (RL11) External filter: no switching, no announce
// (RL12) Forced night and day modes hold
// (RL13) Night withdraws filter, day inserts it
// (RL14) Dwell restarts when crossing lapses
// (RL15) Reset gives day position, announce inactive
`timescale 1ns/10ps
module dnf_ctrl #(
    parameter int CYCLES_PER_SECOND = dnf_pkg::CYC_PER_SEC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Scene measurement and variant
    input wire logic signed [15:0] measured_darkness,
    input wire logic ext_filter_variant,
    // General-purpose pins
    input wire logic [2:0] gpio_in,
    output logic [2:0] gpio_out,
    output logic [2:0] gpio_oe,
    // Filter mechanism
    output logic filter_in_front,
    output logic filter_position_night
);

    function automatic logic is_select(input logic [2:0] cfg);
        is_select = !cfg[0] && (cfg[2:1] == dnf_pkg::FUNC_SELECT);
    endfunction

    function automatic logic is_announce(input logic [2:0] cfg);
        is_announce = cfg[0] && (cfg[2:1] == dnf_pkg::FUNC_ANNOUNCE);
    endfunction

    function automatic logic pos_night(input dnf_pkg::dnf_pos_t p);
        pos_night = (p == dnf_pkg::POS_NIGHT);
    endfunction

    // Configuration state
    logic [1:0] filter_mode_setting_r;
    logic [1:0] filter_mode_setting_nxt;
    logic signed [15:0] darkness_threshold_r;
    logic signed [15:0] darkness_threshold_nxt;
    logic [15:0] dwell_seconds_r;
    logic [15:0] dwell_seconds_nxt;
    logic [8:0] iocfg_r;
    logic [8:0] iocfg_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Decision state
    dnf_pkg::dnf_pos_t pos_r;
    dnf_pkg::dnf_pos_t pos_nxt;
    logic [26:0] sec_cnt_r;
    logic [26:0] sec_cnt_nxt;
    logic [15:0] dwell_cnt_r;
    logic [15:0] dwell_cnt_nxt;
    logic [2:0] out_r;
    logic [2:0] out_nxt;
    logic [2:0] oe_r;
    logic [2:0] oe_nxt;

    logic [2:0] sel_hits;
    logic [2:0] ann_hits;
    logic select_active;
    logic crossing;
    logic second_done;
    logic dwell_done;

    // Port fields are three bits: direction, then function
    genvar gi;
    generate
        for (gi = 0; gi < dnf_pkg::NUM_IO; gi++) begin : g_port
            assign sel_hits[gi] = is_select(iocfg_r[gi*3 +: 3]) && gpio_in[gi]; // RL10
            assign ann_hits[gi] = is_announce(iocfg_r[gi*3 +: 3]); // RL8
        end
    endgenerate

    // Several select-configured inputs are ORed
    assign select_active = |sel_hits;

    // Signed compare: bright scenes go negative
    always_comb begin
        if (pos_r == dnf_pkg::POS_DAY) begin
            crossing = measured_darkness > darkness_threshold_r; // RL3 RL4
        end else begin
            crossing = measured_darkness < darkness_threshold_r; // RL3
        end
    end

    // Inclusive compare: a zero dwell switches on the next edge
    assign dwell_done = (dwell_cnt_r >= dwell_seconds_r); // RL5
    assign second_done = (sec_cnt_r == 27'(CYCLES_PER_SECOND - 1));

    // Register port
    always_comb begin
        filter_mode_setting_nxt = filter_mode_setting_r;
        darkness_threshold_nxt = darkness_threshold_r;
        dwell_seconds_nxt = dwell_seconds_r;
        iocfg_nxt = iocfg_r;
        if (reg_wr) begin
            case (reg_addr)
                dnf_pkg::REG_CTRL: begin
                    filter_mode_setting_nxt = reg_wdata[dnf_pkg::CTRL_MODE_LSB +: 2];
                end
                dnf_pkg::REG_THRESH: begin
                    darkness_threshold_nxt = reg_wdata[15:0]; // RL4
                end
                dnf_pkg::REG_DWELL: begin
                    dwell_seconds_nxt = reg_wdata[15:0]; // RL5
                end
                dnf_pkg::REG_IOCFG: begin
                    iocfg_nxt = reg_wdata[8:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data: one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                dnf_pkg::REG_CTRL: begin
                    rdata_nxt[dnf_pkg::CTRL_MODE_LSB +: 2] = filter_mode_setting_r;
                end
                dnf_pkg::REG_THRESH: begin
                    rdata_nxt = {{16{darkness_threshold_r[15]}}, darkness_threshold_r};
                end
                dnf_pkg::REG_DWELL: begin
                    rdata_nxt[15:0] = dwell_seconds_r;
                end
                dnf_pkg::REG_LEVEL: begin
                    rdata_nxt = {{16{measured_darkness[15]}}, measured_darkness}; // RL6
                end
                dnf_pkg::REG_STATUS: begin
                    rdata_nxt[dnf_pkg::STAT_NIGHT_BIT] = pos_night(pos_r);
                    rdata_nxt[dnf_pkg::STAT_CROSS_BIT] = crossing;
                    rdata_nxt[dnf_pkg::STAT_EXT_BIT] = ext_filter_variant;
                    rdata_nxt[dnf_pkg::STAT_SEL_BIT] = select_active;
                    rdata_nxt[dnf_pkg::STAT_MODE_LSB +: 2] = filter_mode_setting_r;
                end
                dnf_pkg::REG_IOCFG: begin
                    rdata_nxt[8:0] = iocfg_r;
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // Dwell timer: counts only while auto mode sees a crossing
    always_comb begin
        sec_cnt_nxt = 27'h000_0000;
        dwell_cnt_nxt = 16'h0000;
        if (!ext_filter_variant && (filter_mode_setting_r == dnf_pkg::MODE_AUTO)) begin
            if (!crossing) begin
                // Momentary lighting change must not accumulate
                sec_cnt_nxt = 27'h000_0000; // RL14
                dwell_cnt_nxt = 16'h0000; // RL14
            end else if (dwell_done) begin
                // Switching edge: both counters start over
                sec_cnt_nxt = 27'h000_0000;
                dwell_cnt_nxt = 16'h0000;
            end else if (second_done) begin
                dwell_cnt_nxt = dwell_cnt_r + 16'h0001; // RL5
            end else begin
                sec_cnt_nxt = sec_cnt_r + 27'h000_0001;
                dwell_cnt_nxt = dwell_cnt_r;
            end
        end
    end

    // Position decision
    always_comb begin
        pos_nxt = pos_r;
        if (ext_filter_variant) begin
            // Mode is only a presence flag here; mechanism is manual
            pos_nxt = dnf_pkg::POS_DAY; // RL11
        end else begin
            case (filter_mode_setting_r)
                dnf_pkg::MODE_AUTO: begin
                    if (crossing && dwell_done && pos_r == dnf_pkg::POS_DAY) begin
                        pos_nxt = dnf_pkg::POS_NIGHT; // RL1
                    end else if (crossing && dwell_done) begin
                        pos_nxt = dnf_pkg::POS_DAY; // RL2
                    end
                end
                dnf_pkg::MODE_NIGHT: begin
                    pos_nxt = dnf_pkg::POS_NIGHT; // RL12
                end
                dnf_pkg::MODE_DAY: begin
                    pos_nxt = dnf_pkg::POS_DAY; // RL12
                end
                dnf_pkg::MODE_INPUT: begin
                    pos_nxt = select_active ? dnf_pkg::POS_NIGHT : dnf_pkg::POS_DAY; // RL9
                end
                default: begin
                    pos_nxt = pos_r;
                end
            endcase
        end
    end

    // Pin drive: announce ports follow the position, the rest stay off
    always_comb begin
        out_nxt = 3'h0;
        oe_nxt = 3'h0;
        if (!ext_filter_variant) begin // RL11
            oe_nxt = ann_hits; // RL8
            // Same edge as the position, so a relay never lags the filter
            out_nxt = pos_night(pos_nxt) ? ann_hits : 3'h0; // RL7
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            filter_mode_setting_r <= dnf_pkg::RST_MODE;
            darkness_threshold_r <= dnf_pkg::RST_THRESH;
            dwell_seconds_r <= dnf_pkg::RST_DWELL;
            iocfg_r <= dnf_pkg::RST_IOCFG;
        end else begin
            filter_mode_setting_r <= filter_mode_setting_nxt;
            darkness_threshold_r <= darkness_threshold_nxt;
            dwell_seconds_r <= dwell_seconds_nxt;
            iocfg_r <= iocfg_nxt;
        end
    end

    // Read data register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Position register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_r <= dnf_pkg::POS_DAY; // RL15
        end else begin
            pos_r <= pos_nxt;
        end
    end

    // Dwell timer registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_r <= 27'h000_0000;
            dwell_cnt_r <= 16'h0000;
        end else begin
            sec_cnt_r <= sec_cnt_nxt;
            dwell_cnt_r <= dwell_cnt_nxt;
        end
    end

    // Pin registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 3'h0; // RL15
            oe_r <= 3'h0;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign gpio_out = out_r;
    assign gpio_oe = oe_r;
    assign filter_in_front = (pos_r == dnf_pkg::POS_DAY); // RL13
    assign filter_position_night = pos_night(pos_r); // RL13

endmodule

// *** verif/dnf_ctrl_props.sv ***
/* Port checker for the filter controller.
 Assumes a bind from the bench top and a single clock domain. */
`timescale 1ns/10ps
module dnf_ctrl_props (
    // Clock, reset and register port
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Scene, pins and filter
    input wire logic signed [15:0] measured_darkness,
    input wire logic ext_filter_variant,
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe,
    input wire logic filter_in_front,
    input wire logic filter_position_night
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_mode(m);
        reg_wr && reg_addr == dnf_pkg::REG_CTRL && reg_wdata[1:0] == m && !ext_filter_variant;
    endsequence
    property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0000_0000; endproperty
    property p_level; reg_rd && reg_addr == dnf_pkg::REG_LEVEL |=>
        reg_rdata == {{16{$past(measured_darkness[15])}}, $past(measured_darkness)}; endproperty
    property p_sides; filter_position_night != filter_in_front; endproperty
    property p_force_night; s_mode(dnf_pkg::MODE_NIGHT) |-> ##2 filter_position_night; endproperty
    property p_force_day; s_mode(dnf_pkg::MODE_DAY) |-> ##2 filter_in_front; endproperty
    property p_announce; gpio_oe[1] |-> gpio_out[1] == filter_position_night; endproperty
    property p_ext; ext_filter_variant |=> filter_in_front && gpio_oe == 3'h0; endproperty
    property p_reset_day; $rose(rst_n) |-> filter_in_front && gpio_oe == 3'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_level: assert property (p_level) else $error("level read wrong");
    a_sides: assert property (p_sides) else $error("position outputs clash");
    a_force_night: assert property (p_force_night) else $error("no night");
    a_force_day: assert property (p_force_day) else $error("no day");
    a_announce: assert property (p_announce) else $error("announce wrong");
    a_ext: assert property (p_ext) else $error("external variant moved");
    a_reset_day: assert property (p_reset_day) else $error("reset not day");
endmodule

// *** verif/dnf_far_side.sv ***
/* Far side: photocell switch on port 2, relay on port 1.
 Assumes port 1 is the announce output and port 2 the select input. */
`timescale 1ns/10ps
module dnf_far_side (
    // Clock and switch command
    input wire logic core_clk,
    input wire logic dark,
    input wire logic [3:0] lag,
    // Pins
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe,
    output logic [2:0] gpio_in,
    output logic relay_on
);
    logic [3:0] cnt = 4'h0;
    logic sw = 1'h0;
    // Slow contact: closes lag cycles late
    always @(posedge core_clk) begin
        cnt <= (dark == sw) ? 4'h0 : cnt + 4'h1;
        if (dark != sw && cnt >= lag) sw <= dark;
    end
    // Undriven pins rest at pull-down
    assign gpio_in = (gpio_oe & gpio_out) | {sw & !gpio_oe[2], 2'h0};
    assign relay_on = gpio_oe[1] & gpio_out[1];
endmodule

// *** verif/dnf_ctrl_tb.sv ***
/* Bench top: controller, far side and bound checker.
 Assumes a shortened second of four clocks. */
`timescale 1ns/10ps
module dnf_ctrl_tb;
    logic core_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic ext_filter_variant = 1'h0, cmd_dark = 1'h0;
    logic [3:0] reg_addr = 4'h0, lag = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, got;
    logic signed [15:0] measured_darkness = 16'h0000, thr;
    logic [2:0] gpio_in, gpio_out, gpio_oe;
    logic filter_in_front, filter_position_night, relay_on;
    int num_errors = 0, tests_run = 0;
    always #5 core_clk = ~core_clk;
    dnf_ctrl #(.CYCLES_PER_SECOND(4)) dnf_ctrl_inst (.core_clk, .rst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .measured_darkness, .ext_filter_variant,
        .gpio_in, .gpio_out, .gpio_oe, .filter_in_front, .filter_position_night);
    dnf_far_side dnf_far_side_inst (.core_clk, .dark(cmd_dark), .lag, .gpio_out, .gpio_oe,
        .gpio_in, .relay_on);
    function automatic logic [31:0] sext(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (e !== s) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask
    task automatic set_dark(input logic [15:0] v);
        @(posedge core_clk);
        measured_darkness <= v;
    endtask
    task automatic wait_pos(input logic n, input int bound);
        int i;
        #1;
        for (i = 0; i < bound && filter_position_night !== n; i++) tick(1);
        chk("night position", {31'h0, n}, {31'h0, filter_position_night});
        if (i == bound) tally_and_finish();
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h3673_3da7));
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        tick(1);
        chk("reset front", 32'h1, {31'h0, filter_in_front});
        rd(dnf_pkg::REG_DWELL, got);
        chk("dwell", {16'h0000, dnf_pkg::RST_DWELL}, got);
        rd(4'hF, got);
        chk("unmapped", 32'h0000_0000, got);
        repeat (4) begin
            set_dark(16'($urandom));
            wr(dnf_pkg::REG_LEVEL, 32'hFFFF_FFFF);
            rd(dnf_pkg::REG_LEVEL, got);
            chk("level", sext(measured_darkness), got);
        end
        $display("test registers done");
        wr(dnf_pkg::REG_IOCFG, 32'h0000_00A8);
        rd(dnf_pkg::REG_IOCFG, got);
        chk("port config", 32'h0000_00A8, got);
        wr(dnf_pkg::REG_CTRL, {30'h0, dnf_pkg::MODE_NIGHT});
        wait_pos(1'h1, 4);
        chk("relay", 32'h1, {31'h0, relay_on});
        chk("withdrawn", 32'h0, {31'h0, filter_in_front});
        wr(dnf_pkg::REG_CTRL, {30'h0, dnf_pkg::MODE_DAY});
        wait_pos(1'h0, 4);
        chk("relay off", 32'h0, {31'h0, relay_on});
        wr(dnf_pkg::REG_CTRL, {30'h0, dnf_pkg::MODE_INPUT});
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            cmd_dark <= !cmd_dark;
            lag <= 4'($urandom % 8);
            wait_pos(!k[0], 16);
            rd(dnf_pkg::REG_STATUS, got);
            chk("select", {31'h0, !k[0]}, {31'h0, got[dnf_pkg::STAT_SEL_BIT]});
        end
        $display("test forced and pin modes done");
        thr = 16'($urandom % 2000) - 16'h03E8;
        wr(dnf_pkg::REG_THRESH, sext(thr));
        rd(dnf_pkg::REG_THRESH, got);
        chk("threshold", sext(thr), got);
        wr(dnf_pkg::REG_DWELL, 32'h0000_0002);
        set_dark(thr);
        wr(dnf_pkg::REG_CTRL, {30'h0, dnf_pkg::MODE_AUTO});
        tick(20);
        chk("equal level", 32'h0, {31'h0, filter_position_night});
        set_dark(thr + 16'h0001);
        tick(5);
        set_dark(thr);
        set_dark(thr + 16'h0001);
        tick(6);
        chk("dwell restart", 32'h0, {31'h0, filter_position_night});
        wait_pos(1'h1, 12);
        set_dark(thr - 16'h0001);
        tick(6);
        chk("night holds", 32'h1, {31'h0, filter_position_night});
        wait_pos(1'h0, 12);
        $display("test auto done");
        @(posedge core_clk);
        ext_filter_variant <= 1'h1;
        wr(dnf_pkg::REG_CTRL, {30'h0, dnf_pkg::MODE_NIGHT});
        tick(4);
        chk("ext front", 32'h1, {31'h0, filter_in_front});
        chk("ext oe", 32'h0, {29'h0, gpio_oe});
        rd(dnf_pkg::REG_CTRL, got);
        chk("mode kept", {30'h0, dnf_pkg::MODE_NIGHT}, got);
        rd(dnf_pkg::REG_STATUS, got);
        chk("ext status", (32'(dnf_pkg::MODE_NIGHT) << dnf_pkg::STAT_MODE_LSB)
            | (32'h0000_0001 << dnf_pkg::STAT_EXT_BIT), got);
        $display("test external variant done");
        tally_and_finish();
    end
endmodule
bind dnf_ctrl dnf_ctrl_props dnf_ctrl_props_inst (.core_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .measured_darkness, .ext_filter_variant, .gpio_out,
    .gpio_oe, .filter_in_front, .filter_position_night);
